// ===== dv/scan_tester.sv
// Purpose: Behavioural boundary-scan tester on the shared backplane port.
// Assumes: Core clock of 40 ns; one scan bit takes 320 ns (4 low, 4 high).
// Notes: Scan clock idles low between frames and data is inverted there.
`timescale 1ns/100ps
`default_nettype none

module scan_tester
    import scan_select_pkg::*;
(
    input wire logic core_clk_i,
    output scan_select_pkg::scan_pins_t pins_o,
    input wire scan_select_pkg::tdo_drive_t tdo_i
);
    // ======================================================================
    // Bit and frame tasks
    // ======================================================================
    initial pins_o = '0;

    // One bit: data changes with the falling clock, output sampled mid-high.
    task automatic tick(input logic tms, input logic tdi, output tdo_drive_t seen);
        pins_o.tck <= 1'b0;
        pins_o.tms <= tms;
        pins_o.tdi <= tdi;
        repeat (4) @(posedge core_clk_i);
        pins_o.tck <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        seen = tdo_i;
        repeat (2) @(posedge core_clk_i);
    endtask

    // Stop the clock low and leave stale data inverted, never the last bit.
    task automatic idle(input logic last);
        pins_o.tck <= 1'b0;
        pins_o.tdi <= ~last;
        @(posedge core_clk_i);
    endtask

    // Five ones reach Test-Logic-Reset from anywhere, then park in Idle.
    task automatic tlr();
        tdo_drive_t s;
        repeat (5) tick(1'b1, 1'b0, s);
        tick(1'b0, 1'b0, s);
        idle(1'b0);
    endtask

    // Idle to Shift, n bits lsb first, Update, back to Idle.
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
        output logic [31:0] qd, output logic [31:0] qo, output logic [31:0] qw);
        tdo_drive_t s;
        qd = '0;
        qo = '0;
        qw = '0;
        tick(1'b1, 1'b0, s);
        if (ir)
            tick(1'b1, 1'b0, s);
        tick(1'b0, 1'b0, s);
        tick(1'b0, 1'b0, s);
        for (int k = 0; k < n; k++)
        begin
            tick(k == n - 1, din[k], s);
            qd[k] = s.data;
            qo[k] = s.oe;
            qw[k] = s.weak_one;
        end
        tick(1'b1, 1'b0, s);
        tick(1'b0, 1'b0, s);
        idle(din[n - 1]);
    endtask
endmodule

`default_nettype wire

// ===== dv/tb_scan_address_select.sv
// Purpose: Self-checking bench of the scan address select block.
// Assumes: The tester model drives the backplane pins.
// Notes: Scenarios run in order; each leaves the tester in Run-Test/Idle.
`timescale 1ns/100ps
`default_nettype none

module tb_scan_address_select;
    import scan_select_pkg::*;
    // ======================================================================
    // Signals and instances
    // ======================================================================
    localparam logic [31:0] ID = 32'h0A5C_3E71; // Arbitrary identity value.
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [6:0] slot_i = 7'h25;
    logic upd_ready_i = 1'b1;
    scan_pins_t pins;
    tdo_drive_t tdo;
    sel_state_t sel;
    logic [2:0] held;
    logic [1:0] grp;
    logic acc, uval, upk, upk_seen = 1'b0;
    instr_update_t udata;
    logic [31:0] qd, qo, qw;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    scan_tester scan_tester_i (.core_clk_i(core_clk_i), .pins_o(pins), .tdo_i(tdo));
    scan_address_select #(.ID_VALUE(ID)) scan_address_select_i (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .pins_i(pins), .slot_i(slot_i), .tdo_o(tdo), .sel_state_o(sel),
        .held_in_logic_reset_o(held), .unpark_req_o(upk), .group_number_register_o(grp),
        .instr_accept_o(acc), .upd_valid_o(uval), .upd_ready_i(upd_ready_i),
        .upd_data_o(udata));

    // Clock, sticky unpark flag and hang limit.
    initial forever #20 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i)
    begin
        upk_seen <= upk_seen | (upk === 1'b1);
        cycles++;
        if (cycles == 20000)
        begin
            check(1'b0, "timeout");
            finish_test();
        end
    end

    // ======================================================================
    // Shared tasks
    // ======================================================================
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic ir(input logic [7:0] c);
        scan_tester_i.scan(1'b1, 8, {24'h0, c}, qd, qo, qw);
    endtask

    task automatic finish_test();
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ======================================================================
    // Scenarios
    // ======================================================================
    task automatic t_unselected();
        ir(8'h26);
        check(sel === SEL_UNSEL, "no match not unselected");
        check(qo === 32'h0 && qw === 32'h0, "driven while waiting");
        ir({1'b0, slot_i});
        check(sel === SEL_UNSEL && tdo === 3'h0, "unselected left");
        ir(8'hC3);
        check(sel === SEL_WAIT, "return from unselected");
    endtask

    task automatic t_single();
        int k = 0;
        ir({1'b1, slot_i});
        check(sel === SEL_SINGLE, "eighth bit not ignored");
        check(held === 3'h7, "ports left park");
        // The data scan comes first so the default register after selection is seen.
        scan_tester_i.scan(1'b0, 32, 32'h0, qd, qo, qw);
        check(qd === ID && qo === 32'hFFFF_FFFF, "identity out");
        ir(8'hAA);
        check(qo[7:0] === 8'hFF && qd[7:0] === 8'h01, "ir capture out");
        upd_ready_i <= 1'b0;
        for (int i = 0; i < 9; i++)
            ir(8'h90 + 8'(i));
        check(acc === 1'b0 && uval === 1'b1, "full buffer accepts");
        upd_ready_i <= 1'b1;
        // Buffer outputs are sampled mid-cycle, away from the edge that pops them.
        repeat (12)
        begin
            @(negedge core_clk_i);
            if (uval === 1'b1)
            begin
                check(udata === {SEL_SINGLE, 8'h90 + 8'(k)}, "record order");
                k++;
            end
        end
        @(posedge core_clk_i);
        check(k == 8 && uval === 1'b0, "drained count");
        ir(8'h03);
        scan_tester_i.scan(1'b0, 2, 32'h2, qd, qo, qw);
        check(grp === 2'h2, "group write order");
        ir(8'hE7);
        check(held === 3'h0 && upk_seen === 1'b1, "unpark");
        scan_tester_i.tlr();
        check(sel === SEL_WAIT && held === 3'h7, "logic reset");
    endtask

    task automatic t_multi();
        ir(8'h3E);
        check(sel === SEL_GROUP, "group select");
        ir(8'hAA);
        check(qo === 32'h0, "group drove output");
        ir(8'hC3);
        ir(8'h3C);
        check(sel === SEL_UNSEL, "other group selected");
        ir(8'hC3);
        ir(8'h3B);
        check(sel === SEL_BCAST, "broadcast select");
        ir(8'hAA);
        check(qo === 32'h0, "broadcast drove output");
        ir(8'hC3);
        ir(8'h3A);
        check(sel === SEL_INTERROG, "interrogation");
        ir(8'hC3);
        check(qo[7:0] === 8'h25 && qw[7:0] === 8'hDA && qd === 32'h0, "ones complement");
        check(sel === SEL_WAIT && tdo === 3'h0, "back to wait");
    endtask

    // Reset, then the scenarios in order.
    initial
    begin
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        check(sel === SEL_WAIT && grp === 2'h0 && tdo === 3'h0, "reset state");
        check(held === 3'h7, "ports not held");
        scan_tester_i.tlr();
        t_unselected();
        t_single();
        t_multi();
        finish_test();
    end
endmodule

`default_nettype wire

// ===== pkg/scan_select_map.svh
// Purpose: Constants of the multidrop scan address select block.
// Assumes: Included by its bare name wherever a constant is needed.
// Notes: Codes are eight-bit instruction register values.
`ifndef SCAN_SELECT_MAP_SVH
`define SCAN_SELECT_MAP_SVH

// ==========================================================================
// Register widths and reset values
// ==========================================================================
`define MAP_IR_W 8
`define MAP_ID_W 32
`define MAP_GROUP_W 2
`define MAP_IR_CAPTURE 8'h01
`define MAP_GROUP_RESET 2'h0
`define MAP_HELD_RESET 3'h7

// ==========================================================================
// Reserved addresses and instruction codes
// ==========================================================================
`define MAP_ADDR_INTERROGATE 7'h3A
`define MAP_ADDR_BROADCAST 7'h3B
`define MAP_ADDR_GROUP_HI 5'h0F
`define MAP_OP_RETURN_WAIT 8'hC3
`define MAP_OP_UNPARK 8'hE7
`define MAP_OP_GROUP_SEL 8'h03
`define MAP_OP_BYPASS 8'hFF
`define MAP_OP_IDCODE 8'hAA

`endif

// ===== pkg/scan_select_pkg.sv
// Purpose: Types shared by the scan address select block and its buffer.
// Assumes: Nothing beyond plain SystemVerilog.
// Notes: State codes are written out so that traces read the same everywhere.
package scan_select_pkg;

    // ======================================================================
    // Controller states
    // ======================================================================
    typedef enum logic [3:0] {
        TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
        TAP_SHIFT_DR = 4'h4, TAP_EXIT1_DR = 4'h5, TAP_PAUSE_DR = 4'h6,
        TAP_EXIT2_DR = 4'h7, TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9,
        TAP_CAP_IR = 4'hA, TAP_SHIFT_IR = 4'hB, TAP_EXIT1_IR = 4'hC,
        TAP_PAUSE_IR = 4'hD, TAP_EXIT2_IR = 4'hE, TAP_UPD_IR = 4'hF
    } tap_state_t;

    typedef enum logic [2:0] {
        SEL_WAIT = 3'h0, SEL_SINGLE = 3'h1, SEL_GROUP = 3'h2,
        SEL_BCAST = 3'h3, SEL_INTERROG = 3'h4, SEL_UNSEL = 3'h5
    } sel_state_t;

    // ======================================================================
    // Pin groups and buffered records
    // ======================================================================
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } scan_pins_t;

    typedef struct packed {
        logic data;
        logic oe;
        logic weak_one;
    } tdo_drive_t;

    typedef struct packed {
        sel_state_t mode;
        logic [7:0] opcode;
    } instr_update_t;

endpackage

// ===== rtl/instr_fifo.sv
// Purpose: Small flip-flop FIFO for instruction update records.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Depth must be a power of two of at least two.
`timescale 1ns/100ps
`default_nettype none

module instr_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // ======================================================================
    // Parameter check
    // ======================================================================
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad
        $error("instr_fifo needs a power-of-two depth and a nonzero width");
    end

    // Full and empty come straight from the occupancy count.
    assign in_ready_o = (count_r != DEPTH[AW:0]);
    assign out_valid_o = (count_r != '0);
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign out_data_o = mem_r[rd_r];

    // Storage is written only on an accepted push.
    always_ff @(posedge core_clk_i)
    begin
        if (push)
        begin
            mem_r[wr_r] <= in_data_i;
        end
    end

    // Pointers and count move together so full and empty never disagree.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_r <= '0;
            rd_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop)
            begin
                rd_r <= rd_r + 1'b1;
            end
            if (push != pop)
            begin
                count_r <= push ? count_r + 1'b1 : count_r - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ===== rtl/scan_address_select.sv
// Purpose: Level-1 selection logic of a multidrop scan bridge.
// Assumes: Backplane pins are slow next to core_clk_i (at least 4x).
// Notes: Pins are resynchronised and scan clock edges are found by sampling.
`timescale 1ns/100ps
`default_nettype none
`include "scan_select_map.svh"

module scan_address_select
    import scan_select_pkg::*;
#(
    parameter int ADDR_W = 7,
    parameter logic [31:0] ID_VALUE = 32'h1234_5001, // Arbitrary identity value.
    parameter int FIFO_DEPTH = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire scan_select_pkg::scan_pins_t pins_i,
    input wire logic [ADDR_W-1:0] slot_i,
    output scan_select_pkg::tdo_drive_t tdo_o,
    output scan_select_pkg::sel_state_t sel_state_o,
    output logic [2:0] held_in_logic_reset_o,
    output logic unpark_req_o,
    output logic [1:0] group_number_register_o,
    output logic instr_accept_o,
    output logic upd_valid_o,
    input wire logic upd_ready_i,
    output scan_select_pkg::instr_update_t upd_data_o
);
    import scan_select_pkg::*;

    // ======================================================================
    // Parameter check
    // ======================================================================
    if (ADDR_W != 7 && ADDR_W != 8)
    begin : g_bad_addr
        $error("scan_address_select supports seven or eight slot inputs");
    end

    // ======================================================================
    // Pin synchronisers and scan clock edge detection
    // ======================================================================
    scan_pins_t pins_s1_r;
    scan_pins_t pins_s2_r;
    logic [ADDR_W-1:0] slot_s1_r;
    logic [ADDR_W-1:0] slot_s2_r;
    logic tck_d_r;
    logic tck_rise;
    logic tck_fall;

    // Two flops per pin; only the second stage feeds any logic.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pins_s1_r <= '0;
            pins_s2_r <= '0;
            slot_s1_r <= '0;
            slot_s2_r <= '0;
            tck_d_r <= 1'b0;
        end
        else
        begin
            pins_s1_r <= pins_i;
            pins_s2_r <= pins_s1_r;
            slot_s1_r <= slot_i;
            slot_s2_r <= slot_s1_r;
            tck_d_r <= pins_s2_r.tck;
        end
    end

    assign tck_rise = pins_s2_r.tck & ~tck_d_r;
    assign tck_fall = ~pins_s2_r.tck & tck_d_r;

    // ======================================================================
    // Scan controller
    // ======================================================================
    tap_state_t tap_r;
    tap_state_t tap_nxt;

    // The standard sixteen-state walk, steered by the sampled mode pin.
    always_comb
    begin
        tap_nxt = tap_r;
        case (tap_r)
            TAP_RESET: tap_nxt = pins_s2_r.tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_nxt = pins_s2_r.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_nxt = pins_s2_r.tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_nxt = pins_s2_r.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_nxt = pins_s2_r.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_nxt = pins_s2_r.tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_nxt = pins_s2_r.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_nxt = pins_s2_r.tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_nxt = pins_s2_r.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_nxt = pins_s2_r.tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_nxt = pins_s2_r.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_nxt = pins_s2_r.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_nxt = pins_s2_r.tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_nxt = pins_s2_r.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_nxt = pins_s2_r.tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_nxt = pins_s2_r.tms ? TAP_SEL_DR : TAP_IDLE;
            default: tap_nxt = TAP_RESET;
        endcase
    end

    // The controller only moves on a sampled rising edge of the scan clock.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tap_r <= TAP_RESET;
        end
        else if (tck_rise)
        begin
            tap_r <= tap_nxt;
        end
    end

    // ======================================================================
    // Address decode
    // ======================================================================
    logic [7:0] ir_r;
    logic [7:0] instr_r;
    sel_state_t sel_r;
    logic [1:0] group_r;
    logic upd_ir;
    logic addr_hit;
    logic addr_reserved;
    logic group_hit;

    // Reserved codes only exist with the top bit clear; seven-pin parts ignore it.
    function automatic logic low_page(input logic [7:0] code);
        low_page = (ADDR_W == 7) || !code[7];
    endfunction

    assign upd_ir = tck_rise && (tap_r == TAP_UPD_IR);
    assign addr_hit = (ir_r[ADDR_W-1:0] == slot_s2_r);
    assign addr_reserved = low_page(ir_r) && (ir_r[6:2] == `MAP_ADDR_GROUP_HI ||
        ir_r[6:0] == `MAP_ADDR_INTERROGATE || ir_r[6:0] == `MAP_ADDR_BROADCAST);
    assign group_hit = low_page(ir_r) && (ir_r[6:2] == `MAP_ADDR_GROUP_HI) &&
        (ir_r[1:0] == group_r);

    // ======================================================================
    // Selection controller
    // ======================================================================
    // Reserved codes win over the slot compare, since a slot never holds one.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sel_r <= SEL_WAIT;
        end
        else if (tap_r == TAP_RESET)
        begin
            sel_r <= SEL_WAIT;
        end
        else if (upd_ir && ir_r == `MAP_OP_RETURN_WAIT)
        begin
            sel_r <= SEL_WAIT;
        end
        else if (upd_ir && sel_r == SEL_WAIT)
        begin
            if (low_page(ir_r) && ir_r[6:0] == `MAP_ADDR_INTERROGATE)
                sel_r <= SEL_INTERROG;
            else if (low_page(ir_r) && ir_r[6:0] == `MAP_ADDR_BROADCAST)
                sel_r <= SEL_BCAST;
            else if (group_hit)
                sel_r <= SEL_GROUP;
            else if (!addr_reserved && addr_hit)
                sel_r <= SEL_SINGLE;
            else
                sel_r <= SEL_UNSEL;
        end
    end

    logic selected;
    assign selected = (sel_r == SEL_SINGLE) || (sel_r == SEL_GROUP) ||
        (sel_r == SEL_BCAST);

    // ======================================================================
    // Instruction register
    // ======================================================================
    // new bits enter at the top
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ir_r <= `MAP_IR_CAPTURE;
        end
        else if (tck_rise && tap_r == TAP_CAP_IR)
        begin
            // in interrogation the complement of the address is loaded to be read back, else the capture value
            ir_r <= (sel_r == SEL_INTERROG) ? ~8'(slot_s2_r) : `MAP_IR_CAPTURE;
        end
        else if (tck_rise && tap_r == TAP_SHIFT_IR)
        begin
            ir_r <= {pins_s2_r.tdi, ir_r[7:1]};
        end
    end

    // Active instruction; a fresh selection falls back to identification.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            instr_r <= `MAP_OP_IDCODE;
        end
        else if (tap_r == TAP_RESET)
        begin
            instr_r <= `MAP_OP_IDCODE;
        end
        else if (upd_ir && !selected)
        begin
            instr_r <= `MAP_OP_IDCODE;
        end
        else if (upd_ir)
        begin
            instr_r <= ir_r;
        end
    end

    // ======================================================================
    // Data registers
    // ======================================================================
    logic [31:0] dr_r;

    // data enters each register at its top bit
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            dr_r <= '0;
        end
        else if (tck_rise && tap_r == TAP_CAP_DR)
        begin
            case (instr_r)
                `MAP_OP_GROUP_SEL: dr_r <= {30'h0, group_r};
                `MAP_OP_BYPASS: dr_r <= 32'h0;
                default: dr_r <= ID_VALUE;
            endcase
        end
        else if (tck_rise && tap_r == TAP_SHIFT_DR)
        begin
            case (instr_r)
                `MAP_OP_GROUP_SEL: dr_r[1:0] <= {pins_s2_r.tdi, dr_r[1]};
                `MAP_OP_BYPASS: dr_r[0] <= pins_s2_r.tdi;
                default: dr_r <= {pins_s2_r.tdi, dr_r[31:1]};
            endcase
        end
    end

    // Group register is reachable only while singly selected.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            group_r <= `MAP_GROUP_RESET;
        end
        else if (tck_rise && tap_r == TAP_UPD_DR && sel_r == SEL_SINGLE &&
            instr_r == `MAP_OP_GROUP_SEL)
        begin
            group_r <= dr_r[1:0];
        end
    end

    // ======================================================================
    // Backplane serial output
    // ======================================================================
    // Changes on the falling scan clock edge, as a shared line expects.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tdo_o <= '0;
        end
        else if (tck_fall)
        begin
            tdo_o <= '0;
            if (sel_r == SEL_SINGLE && tap_r == TAP_SHIFT_IR)
                tdo_o <= '{data: ir_r[0], oe: 1'b1, weak_one: 1'b0};
            else if (sel_r == SEL_SINGLE && tap_r == TAP_SHIFT_DR)
                tdo_o <= '{data: dr_r[0], oe: 1'b1, weak_one: 1'b0};
            else if (sel_r == SEL_INTERROG && tap_r == TAP_SHIFT_IR)
                tdo_o <= '{data: 1'b0, oe: !ir_r[0], weak_one: ir_r[0]};
        end
    end

    // ======================================================================
    // Local port hold and unpark request
    // ======================================================================
    logic unpark_upd;
    assign unpark_upd = upd_ir && selected && ir_r == `MAP_OP_UNPARK;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            held_in_logic_reset_o <= `MAP_HELD_RESET;
            unpark_req_o <= 1'b0;
        end
        else
        begin
            unpark_req_o <= unpark_upd;
            if (unpark_upd)
                held_in_logic_reset_o <= 3'h0;
            else if (tap_r == TAP_RESET)
                held_in_logic_reset_o <= `MAP_HELD_RESET;
        end
    end

    // ======================================================================
    // Update record buffer toward the instruction decoder
    // ======================================================================
    // A full buffer drops the record; instr_accept_o tells the decoder so.
    instr_fifo #(
        .WIDTH($bits(instr_update_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .in_valid_i(upd_ir && selected),
        .in_ready_o(instr_accept_o),
        .in_data_i({sel_r, ir_r}),
        .out_valid_o(upd_valid_o),
        .out_ready_i(upd_ready_i),
        .out_data_o(upd_data_o)
    );

    assign sel_state_o = sel_r;
    assign group_number_register_o = group_r;

    // ======================================================================
    // Checks
    // ======================================================================
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_wait_update;
        (sel_r == SEL_WAIT) && upd_ir && ir_r != `MAP_OP_RETURN_WAIT;
    endsequence
    sequence s_quiet_mode;
        sel_r == SEL_WAIT || sel_r == SEL_UNSEL || sel_r == SEL_BCAST;
    endsequence

    a_reset_to_wait: assert property ((tap_r == TAP_RESET) |=> sel_r == SEL_WAIT)
        else $error("reset did not return to waiting");
    a_return_wait: assert property (upd_ir && ir_r == `MAP_OP_RETURN_WAIT && tap_r == TAP_UPD_IR
        |=> sel_r == SEL_WAIT)
        else $error("return-to-wait ignored");
    a_unsel_sticks: assert property (sel_r == SEL_UNSEL && tap_r != TAP_RESET &&
        !(upd_ir && ir_r == `MAP_OP_RETURN_WAIT) |=> sel_r == SEL_UNSEL)
        else $error("unselected state left early");
    a_direct_select: assert property (s_wait_update ##0 (addr_hit && !addr_reserved)
        |=> sel_r == SEL_SINGLE ##0 instr_r == `MAP_OP_IDCODE)
        else $error("direct address did not select with identification");
    a_no_match: assert property (s_wait_update ##0 (!addr_hit && !addr_reserved)
        |=> sel_r == SEL_UNSEL)
        else $error("mismatch did not unselect");
    a_quiet_output: assert property (s_quiet_mode ##1 s_quiet_mode |-> !tdo_o.oe)
        else $error("output driven while waiting, unselected or broadcast");
    a_group_quiet: assert property ((sel_r == SEL_GROUP)[*2] |-> !tdo_o.oe)
        else $error("output driven in group selection");
    a_interrog_drive: assert property (tdo_o.oe |-> !(tdo_o.weak_one) &&
        (sel_r != SEL_INTERROG || !tdo_o.data))
        else $error("interrogation drove a strong one");
    a_ir_msb_entry: assert property (tck_rise && tap_r == TAP_SHIFT_IR
        |=> ir_r[7] == $past(pins_s2_r.tdi) && ir_r[6:0] == $past(ir_r[7:1]))
        else $error("instruction bits did not enter at the top");
    a_unpark_gate: assert property (unpark_req_o |-> $past(selected))
        else $error("unpark requested while not selected");

endmodule

`default_nettype wire
